// ==== logic/ccp_regfile.sv ====
/*
 * Crypto coprocessor register frame: command decode, status register,
 * accumulator and general registers, store read-out path.
 * Assumes the core presents one longword command per clock, synchronous to
 * core_clk, and moves operands and results to and from memory itself.
 */
`timescale 1ns/1ps
`include "ccp_params.svh"

module ccp_regfile #(
	parameter int         GP_COUNT     = 6,
	parameter logic [3:0] IMPL_VERSION = 4'h3 // Arbitrary version code.
) (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic               cmd_valid,
	input  wire logic               cmd_store,
	input  wire ccp_pkg::ccp_cmd_t  cmd_code,
	input  wire ccp_pkg::ccp_word_t cmd_operand,
	output logic                    cmd_illegal,
	output logic                    result_valid,
	output ccp_pkg::ccp_word_t      result_data,
	output logic                    illegal_command_flag,
	output logic                    key_parity_error_flag
);

	// ------------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------------
	// The shift command reaches general register 4, so fewer than five cannot work.
	if (GP_COUNT < 5 || GP_COUNT > 6) begin : g_bad_count
		$error("GP_COUNT must be 5 or 6");
	end

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	ccp_pkg::ccp_word_t acc_q;
	ccp_pkg::ccp_word_t acc_d;
	ccp_pkg::ccp_word_t gp_q [GP_COUNT];
	ccp_pkg::ccp_word_t gp_d [GP_COUNT];
	logic               ic_q;
	logic               ic_d;
	logic               dpe_q;
	logic               dpe_d;
	logic               res_valid_q;
	logic               res_valid_d;
	ccp_pkg::ccp_word_t res_data_q;
	ccp_pkg::ccp_word_t res_data_d;

	// ------------------------------------------------------------------------
	// Command field decode
	// ------------------------------------------------------------------------
	ccp_pkg::ccp_op_t   op;
	ccp_pkg::ccp_code_t reg_code;
	ccp_pkg::ccp_word_t status_word;
	ccp_pkg::ccp_word_t sel_val;
	ccp_pkg::ccp_word_t alu_dst;
	ccp_pkg::ccp_word_t alu_acc;
	logic               alu_dst_we;
	logic               alu_acc_we;
	logic               legal;
	logic               load_go;
	logic               store_go;

	assign op       = cmd_code[`CCP_OP_MSB:`CCP_OP_LSB];
	assign reg_code = cmd_code[3:0];

	// A code names a register if it falls inside status, accumulator or the GP range.
	function automatic logic code_ok(input ccp_pkg::ccp_code_t c);
		return ({28'h0, c} < 32'(GP_COUNT + 2));
	endfunction : code_ok

	function automatic int gp_index(input ccp_pkg::ccp_code_t c);
		return int'(c) - int'(`CCP_CODE_GP0);
	endfunction : gp_index

	// Command legality; reserved encodings and misused fixed fields are illegal.
	function automatic logic cmd_legal(input logic st, input ccp_pkg::ccp_cmd_t c);
		ccp_pkg::ccp_op_t   o;
		ccp_pkg::ccp_code_t lo;
		logic               ok;
		o  = c[`CCP_OP_MSB:`CCP_OP_LSB];
		lo = c[3:0];
		ok = 1'b0;
		if (st) begin
			ok = (o == `CCP_OP_STR) && code_ok(lo);
		end else begin
			unique case (o)
				`CCP_OP_CNOP, `CCP_OP_AESR, `CCP_OP_AESIR, `CCP_OP_SHS: begin
					ok = (lo == 4'h0);
				end
				`CCP_OP_LDR, `CCP_OP_ADR, `CCP_OP_RADR, `CCP_OP_ADRA,
				`CCP_OP_XOR, `CCP_OP_ROTL, `CCP_OP_MVRA, `CCP_OP_MVAR,
				`CCP_OP_AESS, `CCP_OP_AESIS, `CCP_OP_AESC, `CCP_OP_AESIC: begin
					ok = code_ok(lo);
				end
				`CCP_OP_DESR: begin
					ok = 1'b1;
				end
				`CCP_OP_DESK: begin
					ok = (lo[3:2] == 2'h0);
				end
				`CCP_OP_HASH: begin
					ok = ~lo[3];
				end
				default: begin
					ok = 1'b0;
				end
			endcase
		end
		return ok;
	endfunction : cmd_legal

	// DES keys carry odd parity in every byte; any even byte is an error.
	function automatic logic key_parity_bad(input ccp_pkg::ccp_word_t w);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			bad = bad | ~(^w[8*i +: 8]);
		end
		return bad;
	endfunction : key_parity_bad

	function automatic ccp_pkg::ccp_word_t rot(input ccp_pkg::ccp_word_t v, input logic [4:0] n);
		return (v << n) | (v >> (6'h20 - {1'b0, n}));
	endfunction : rot

	assign legal       = cmd_legal(cmd_store, cmd_code);
	assign load_go     = cmd_valid && !cmd_store && legal;
	assign store_go    = cmd_valid && cmd_store && legal;
	assign cmd_illegal = cmd_valid && !legal;

	// ------------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------------
	// Version sits in fixed logic; stored bits above 1 do not exist.
	assign status_word = {IMPL_VERSION, 26'h0, dpe_q, ic_q};

	always_comb begin
		sel_val = `CCP_DATA_RESET;
		if (reg_code == `CCP_CODE_STATUS) begin
			sel_val = status_word;
		end else if (reg_code == `CCP_CODE_ACC) begin
			sel_val = acc_q;
		end else begin
			for (int i = 0; i < GP_COUNT; i++) begin
				if (gp_index(reg_code) == i) begin
					sel_val = gp_q[i];
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// ALU
	// ------------------------------------------------------------------------
	ccp_alu u_alu (
		.op       (op),
		.dst_val  (sel_val),
		.op1      (cmd_operand),
		.acc_val  (acc_q),
		.dst_next (alu_dst),
		.acc_next (alu_acc),
		.dst_we   (alu_dst_we),
		.acc_we   (alu_acc_we)
	);

	// ------------------------------------------------------------------------
	// Register file next state
	// ------------------------------------------------------------------------
	// Every legal load completes in one cycle, so back-to-back commands need no stall.
	always_comb begin
		acc_d = acc_q;
		gp_d  = gp_q;
		ic_d  = ic_q;
		dpe_d = dpe_q;
		if (cmd_illegal) begin
			ic_d = 1'b1;
		end
		if (load_go) begin
			unique case (op)
				`CCP_OP_SHS: begin
					acc_d   = rot(acc_q, `CCP_SHS_ACC_ROT);
					gp_d[0] = acc_q;
					gp_d[1] = gp_q[0];
					gp_d[2] = rot(gp_q[1], `CCP_SHS_CA1_ROT);
					gp_d[3] = gp_q[2];
					gp_d[4] = gp_q[3];
				end
				`CCP_OP_DESK: begin
					if (cmd_code[`CCP_DESK_CP_BIT] && (key_parity_bad(gp_q[0]) || key_parity_bad(gp_q[1]))) begin
						dpe_d = 1'b1;
					end
				end
				default: begin
					if (alu_dst_we) begin
						if (reg_code == `CCP_CODE_STATUS) begin
							ic_d  = alu_dst[`CCP_ST_IC_BIT];
							dpe_d = alu_dst[`CCP_ST_DPE_BIT];
						end else if (reg_code == `CCP_CODE_ACC) begin
							acc_d = alu_dst;
						end else begin
							for (int i = 0; i < GP_COUNT; i++) begin
								if (gp_index(reg_code) == i) begin
									gp_d[i] = alu_dst;
								end
							end
						end
					end
					if (alu_acc_we) begin
						acc_d = alu_acc;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q <= `CCP_DATA_RESET;
			for (int i = 0; i < GP_COUNT; i++) begin
				gp_q[i] <= `CCP_DATA_RESET;
			end
			ic_q  <= 1'b0;
			dpe_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			gp_q  <= gp_d;
			ic_q  <= ic_d;
			dpe_q <= dpe_d;
		end
	end

	// ------------------------------------------------------------------------
	// Store read-out
	// ------------------------------------------------------------------------
	// The result is the register value before any update in the same cycle.
	always_comb begin
		res_valid_d = store_go;
		res_data_d  = res_data_q;
		if (store_go) begin
			res_data_d = sel_val;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			res_valid_q <= 1'b0;
			res_data_q  <= `CCP_DATA_RESET;
		end else begin
			res_valid_q <= res_valid_d;
			res_data_q  <= res_data_d;
		end
	end

	assign result_valid          = res_valid_q;
	assign result_data           = res_data_q;
	assign illegal_command_flag  = ic_q;
	assign key_parity_error_flag = dpe_q;

endmodule : ccp_regfile

// ==== logic/ccp_params.svh ====
/*
 * Constants of the crypto coprocessor register frame: register codes, status
 * field positions, reset values and command encodings.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register codes
// ----------------------------------------------------------------------------
`define CCP_CODE_STATUS 4'h0
`define CCP_CODE_ACC    4'h1
`define CCP_CODE_GP0    4'h2

// ----------------------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------------------
`define CCP_ST_IC_BIT   0
`define CCP_ST_DPE_BIT  1
`define CCP_ST_VER_LSB  28
`define CCP_DATA_RESET  32'h0000_0000

// ----------------------------------------------------------------------------
// Command field layout and opcodes
// ----------------------------------------------------------------------------
`define CCP_OP_MSB      8
`define CCP_OP_LSB      4
`define CCP_DESK_CP_BIT 1
`define CCP_OP_CNOP     5'h00
`define CCP_OP_LDR      5'h01
`define CCP_OP_STR      5'h02
`define CCP_OP_ADR      5'h03
`define CCP_OP_RADR     5'h04
`define CCP_OP_ADRA     5'h05
`define CCP_OP_XOR      5'h06
`define CCP_OP_ROTL     5'h07
`define CCP_OP_MVRA     5'h08
`define CCP_OP_MVAR     5'h09
`define CCP_OP_AESS     5'h0a
`define CCP_OP_AESIS    5'h0b
`define CCP_OP_AESC     5'h0c
`define CCP_OP_AESIC    5'h0d
`define CCP_OP_AESR     5'h0e
`define CCP_OP_AESIR    5'h0f
`define CCP_OP_DESR     5'h10
`define CCP_OP_DESK     5'h11
`define CCP_OP_HASH     5'h12
`define CCP_OP_SHS      5'h13
`define CCP_SHS_ACC_ROT 5'h05
`define CCP_SHS_CA1_ROT 5'h1e

`endif

// ==== logic/ccp_pkg.sv ====
/*
 * Types shared by the crypto coprocessor register frame.
 * Assumes ccp_params.svh is on the include path.
 */
`include "ccp_params.svh"

package ccp_pkg;

	// ------------------------------------------------------------------------
	// Data and command types
	// ------------------------------------------------------------------------
	typedef logic [31:0] ccp_word_t;
	typedef logic [8:0]  ccp_cmd_t;
	typedef logic [4:0]  ccp_op_t;
	typedef logic [3:0]  ccp_code_t;

endpackage : ccp_pkg

// ==== logic/ccp_alu.sv ====
/*
 * Combinational ALU of the coprocessor: the single-register arithmetic and
 * move commands. Assumes the caller masks writes to the status register.
 */
`timescale 1ns/1ps
`include "ccp_params.svh"

module ccp_alu (
	input  wire ccp_pkg::ccp_op_t   op,
	input  wire ccp_pkg::ccp_word_t dst_val,
	input  wire ccp_pkg::ccp_word_t op1,
	input  wire ccp_pkg::ccp_word_t acc_val,
	output ccp_pkg::ccp_word_t      dst_next,
	output ccp_pkg::ccp_word_t      acc_next,
	output logic                    dst_we,
	output logic                    acc_we
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic ccp_pkg::ccp_word_t rotl(input ccp_pkg::ccp_word_t v, input logic [4:0] n);
		ccp_pkg::ccp_word_t r;
		r = (v << n) | (v >> (6'h20 - {1'b0, n}));
		return r;
	endfunction : rotl

	function automatic ccp_pkg::ccp_word_t byte_rev(input ccp_pkg::ccp_word_t v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : byte_rev

	// ------------------------------------------------------------------------
	// Operation select
	// ------------------------------------------------------------------------
	always_comb begin
		dst_next = dst_val;
		acc_next = acc_val;
		dst_we   = 1'b0;
		acc_we   = 1'b0;
		unique case (op)
			`CCP_OP_LDR: begin
				dst_next = op1;
				dst_we   = 1'b1;
			end
			`CCP_OP_ADR: begin
				dst_next = dst_val + op1;
				dst_we   = 1'b1;
			end
			`CCP_OP_RADR: begin
				dst_next = dst_val + byte_rev(op1);
				dst_we   = 1'b1;
			end
			`CCP_OP_ADRA: begin
				acc_next = dst_val + acc_val;
				acc_we   = 1'b1;
			end
			`CCP_OP_XOR: begin
				dst_next = dst_val ^ op1;
				dst_we   = 1'b1;
			end
			`CCP_OP_ROTL: begin
				dst_next = rotl(dst_val, op1[4:0]);
				dst_we   = 1'b1;
			end
			`CCP_OP_MVRA: begin
				acc_next = dst_val;
				acc_we   = 1'b1;
			end
			`CCP_OP_MVAR: begin
				dst_next = acc_val;
				dst_we   = 1'b1;
			end
			default: begin
				dst_we = 1'b0;
			end
		endcase
	end

endmodule : ccp_alu

// ==== tb/ccp_regfile_checker.sv ====
/*
 * Concurrent checks on the ports of the coprocessor register frame.
 * Assumes it is bound to ccp_regfile and sees only its ports and parameters.
 */
`timescale 1ns/1ps

module ccp_regfile_checker #(
	parameter int         GP_COUNT     = 6,
	parameter logic [3:0] IMPL_VERSION = 4'h3
) (
	input wire logic               core_clk,
	input wire logic               rst_b,
	input wire logic               cmd_valid,
	input wire logic               cmd_store,
	input wire ccp_pkg::ccp_cmd_t  cmd_code,
	input wire ccp_pkg::ccp_word_t cmd_operand,
	input wire logic               cmd_illegal,
	input wire logic               result_valid,
	input wire ccp_pkg::ccp_word_t result_data,
	input wire logic               illegal_command_flag,
	input wire logic               key_parity_error_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// A load to code 0 is the only way software can rewrite the flags; this is a superset of those loads.
	logic good_st;
	logic wr_status;
	assign good_st   = cmd_valid && cmd_store && !cmd_illegal;
	assign wr_status = cmd_valid && !cmd_store && cmd_code[3:0] == 4'h0;

	AST_STORE_RESULT: assert property (good_st |=> result_valid)
		else $error("legal store gave no result");
	AST_RESULT_CAUSE: assert property (result_valid |-> $past(good_st))
		else $error("result without a legal store");
	AST_RESULT_HOLDS: assert property (!result_valid |-> $stable(result_data))
		else $error("result data moved without a store");
	AST_STORE_ONLY_READOUT: assert property (cmd_valid && cmd_store && cmd_code[8:4] != 5'h02 |-> cmd_illegal)
		else $error("store of other command accepted");
	AST_CODE_RANGE: assert property (cmd_valid && cmd_code[8:4] == 5'h01 && cmd_code[3:0] > 4'(GP_COUNT + 1)
		|-> cmd_illegal)
		else $error("register code beyond file accepted");
	AST_ILLEGAL_SETS: assert property (cmd_illegal |=> illegal_command_flag)
		else $error("illegal command left flag clear");
	AST_IC_CAUSE: assert property ($rose(illegal_command_flag) |-> $past(cmd_illegal || wr_status))
		else $error("illegal flag rose without cause");
	AST_IC_HOLDS: assert property ($fell(illegal_command_flag) |-> $past(wr_status))
		else $error("illegal flag cleared without status write");
	AST_DPE_HOLDS: assert property ($fell(key_parity_error_flag) |-> $past(wr_status))
		else $error("parity flag cleared without status write");
	AST_DPE_CAUSE: assert property ($rose(key_parity_error_flag)
		|-> $past(wr_status || (cmd_valid && !cmd_store && cmd_code[8:4] == 5'h11 && cmd_code[1])))
		else $error("parity flag rose without key setup");
	AST_STATUS_READ: assert property (good_st && cmd_code[3:0] == 4'h0
		|=> result_data == {IMPL_VERSION, 26'h0, $past(key_parity_error_flag), $past(illegal_command_flag)})
		else $error("status read-out wrong");
endmodule : ccp_regfile_checker

// ==== tb/ccp_core_model.sv ====
/*
 * Model of the issuing core: drives one command per call on the command port.
 * Assumes the caller sequences loads and stores; launches on the rising edge.
 */
`timescale 1ns/1ps

module ccp_core_model (
	input  wire logic          core_clk,
	output logic               cmd_valid,
	output logic               cmd_store,
	output ccp_pkg::ccp_cmd_t  cmd_code,
	output ccp_pkg::ccp_word_t cmd_operand
);
	initial begin
		cmd_valid   = 1'b0;
		cmd_store   = 1'b0;
		cmd_code    = 9'h000;
		cmd_operand = 32'h0000_0000;
	end

	task automatic issue(input logic st, input ccp_pkg::ccp_cmd_t code, input ccp_pkg::ccp_word_t opnd);
		@(posedge core_clk);
		cmd_valid   <= 1'b1;
		cmd_store   <= st;
		cmd_code    <= code;
		cmd_operand <= opnd;
	endtask : issue

	// Released code and operand lines flip so that a stale value never passes for a command.
	task automatic idle();
		@(posedge core_clk);
		cmd_valid   <= 1'b0;
		cmd_code    <= ~cmd_code;
		cmd_operand <= ~cmd_operand;
	endtask : idle
endmodule : ccp_core_model

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the coprocessor register frame with a core model.
 * Assumes the design package is compiled first and the header is on the path.
 */
`timescale 1ns/1ps

module tb;
	localparam int         GP_COUNT     = 6;
	localparam logic [3:0] IMPL_VERSION = 4'h3; // Arbitrary version code.
	logic core_clk = 1'b0;
	logic rst_b    = 1'b0;
	logic cmd_valid, cmd_store, cmd_illegal, result_valid, illegal_command_flag, key_parity_error_flag;
	ccp_pkg::ccp_cmd_t  cmd_code;
	ccp_pkg::ccp_word_t cmd_operand, result_data;
	ccp_pkg::ccp_word_t seed = 32'hfbb3;
	ccp_pkg::ccp_word_t rf [8];
	ccp_pkg::ccp_op_t   ops [8] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09};
	int err_total  = 0;
	int num_checks = 0;

	always #2 core_clk = ~core_clk;

	ccp_regfile #(.GP_COUNT(GP_COUNT), .IMPL_VERSION(IMPL_VERSION)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_store(cmd_store), .cmd_code(cmd_code), .cmd_operand(cmd_operand),
		.cmd_illegal(cmd_illegal), .result_valid(result_valid), .result_data(result_data),
		.illegal_command_flag(illegal_command_flag), .key_parity_error_flag(key_parity_error_flag));
	ccp_core_model core (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_store(cmd_store),
		.cmd_code(cmd_code), .cmd_operand(cmd_operand));

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic ccp_pkg::ccp_word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Reference image of the file; entry 0 mirrors the status register.
	function automatic void model(input ccp_pkg::ccp_op_t op, input logic [3:0] c, input ccp_pkg::ccp_word_t v);
		case (op)
			5'h01: rf[c] = v;
			5'h03: rf[c] = rf[c] + v;
			5'h04: rf[c] = rf[c] + {v[7:0], v[15:8], v[23:16], v[31:24]};
			5'h05: rf[1] = rf[c] + rf[1];
			5'h06: rf[c] = rf[c] ^ v;
			5'h07: rf[c] = (rf[c] << v[4:0]) | (rf[c] >> (6'd32 - v[4:0]));
			5'h08: rf[1] = rf[c];
			5'h09: rf[c] = rf[1];
			5'h13: begin
				rf[6] = rf[5];
				rf[5] = rf[4];
				rf[4] = {rf[3][1:0], rf[3][31:2]};
				rf[3] = rf[2];
				rf[2] = rf[1];
				rf[1] = {rf[1][26:0], rf[1][31:27]};
			end
			default: ;
		endcase
		rf[0] = {IMPL_VERSION, 26'h0, rf[0][1:0]};
	endfunction : model

	task automatic chk(input ccp_pkg::ccp_word_t seen, input ccp_pkg::ccp_word_t exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ld(input ccp_pkg::ccp_op_t op, input logic [3:0] c, input ccp_pkg::ccp_word_t v);
		core.issue(1'b0, {op, c}, v);
		model(op, c, v);
	endtask : ld

	task automatic st(input logic [3:0] c);
		core.issue(1'b1, {5'h02, c}, rnd());
		core.idle();
		#1;
		chk({31'h0, result_valid}, 32'h1);
		chk(result_data, rf[c]);
		chk({30'h0, key_parity_error_flag, illegal_command_flag}, {30'h0, rf[0][1:0]});
	endtask : st

	task automatic try(input logic s, input ccp_pkg::ccp_cmd_t code, input logic ill);
		core.issue(s, code, rnd());
		#1;
		chk({31'h0, cmd_illegal}, {31'h0, ill});
		if (ill)
			rf[0][0] = 1'b1;
	endtask : try

	task automatic dump_all(input string name);
		for (int i = 0; i < 8; i++)
			st(4'(i));
		$display("test %s done", name);
	endtask : dump_all

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8; i++)
			rf[i] = 32'h0000_0000;
		rf[0] = {IMPL_VERSION, 28'h0};
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		dump_all("reset");
		repeat (30) begin
			ld(ops[rnd() % 8], 4'(1 + rnd() % 7), rnd());
			ld(ops[rnd() % 8], 4'(1 + rnd() % 7), rnd());
			ld(5'h13, 4'h0, rnd());
			st(4'(rnd() % 8));
		end
		dump_all("random");
		ld(5'h01, 4'h0, 32'hffff_ffff);
		st(4'h0);
		ld(5'h01, 4'h0, 32'h0000_0000);
		st(4'h0);
		try(1'b1, {5'h01, 4'h2}, 1'b1);
		try(1'b0, {5'h14, 4'h0}, 1'b1);
		try(1'b0, {5'h02, 4'h2}, 1'b1);
		try(1'b1, {5'h02, 4'hf}, 1'b1);
		try(1'b0, {5'h01, 4'h8}, 1'b1);
		dump_all("illegal");
		ld(5'h01, 4'h0, 32'h0000_0000);
		for (int k = 0; k < 20; k++)
			if (k == 0 || (k >= 10 && k <= 16) || k == 18)
				try(1'b0, {5'(k), 4'h0}, 1'b0);
		dump_all("legal");
		ld(5'h01, 4'h2, 32'h0000_0000);
		ld(5'h01, 4'h3, 32'h0101_0101);
		try(1'b0, {5'h11, 4'h0}, 1'b0);
		st(4'h0);
		try(1'b0, {5'h11, 4'h2}, 1'b0);
		rf[0][1] = 1'b1;
		st(4'h0);
		ld(5'h01, 4'h0, 32'h0000_0000);
		ld(5'h01, 4'h2, 32'h0101_0101);
		try(1'b0, {5'h11, 4'h2}, 1'b0);
		st(4'h0);
		ld(5'h01, 4'h0, 32'h0000_0003);
		st(4'h0);
		$display("test key parity done");
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 1; i < 8; i++)
			rf[i] = 32'h0000_0000;
		rf[0] = {IMPL_VERSION, 28'h0};
		dump_all("second reset");
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		tally_and_finish();
	end
endmodule : tb

bind ccp_regfile ccp_regfile_checker #(.GP_COUNT(GP_COUNT), .IMPL_VERSION(IMPL_VERSION)) u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_store(cmd_store), .cmd_code(cmd_code),
	.cmd_operand(cmd_operand), .cmd_illegal(cmd_illegal), .result_valid(result_valid),
	.result_data(result_data), .illegal_command_flag(illegal_command_flag),
	.key_parity_error_flag(key_parity_error_flag));
